/* design/rmis_defines.vh */
`ifndef RMIS_DEFINES_VH
`define RMIS_DEFINES_VH

// Register byte offsets on the APB slave
`define RMIS_OFF_LOCK 12'h000
`define RMIS_OFF_TMRCLK 12'h008
`define RMIS_OFF_CAP1 12'h00c
`define RMIS_OFF_CAP2 12'h010
`define RMIS_OFF_CAP3 12'h014
`define RMIS_OFF_CAP4 12'h018
`define RMIS_OFF_FAULT 12'h02c
`define RMIS_OFF_PWM89 12'h030
`define RMIS_OFF_PWM1011 12'h034
`define RMIS_OFF_ENCAB 12'h038
`define RMIS_OFF_ENCHI 12'h03c

// Field positions
`define RMIS_HI_MSB 15
`define RMIS_HI_LSB 8
`define RMIS_LO_MSB 7
`define RMIS_LO_LSB 0
`define RMIS_LOCK_BIT 11

// Reset values
`define RMIS_SEL_RST 8'h00
`define RMIS_LOCK_RST 1'h0

`endif

/* design/rmis_pin_pick.v */
`timescale 1ns/1ps
`default_nettype none

// One routed input: select value to pin level, registered
module rmis_pin_pick #(
    parameter NPINS = 256
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Selection
    input wire [7:0] sel_i,
    input wire [NPINS-1:0] pins_i,
    // Routed level
    output reg out_o
);

    // Values past the last pin read as low, like an unconnected input
    wire pick = ({24'h000000, sel_i} < NPINS) ? pins_i[sel_i] : 1'b0;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_o <= 1'b0;
        end else begin
            out_o <= pick;
        end
    end

endmodule // rmis_pin_pick

`default_nettype wire

/* design/rmis_top.v */
// Behaviour
// - Timer external clock comes from pin chosen by upper byte of its register.
// - Four capture inputs each routed from pin chosen by their upper byte.
// - Four capture timer clocks routed from pin chosen by lower byte.
// - Compare fault B uses upper byte, fault A lower byte, one register.
// - PWM inputs 8,10 use lower bytes; 9,11 upper bytes of two registers.
// - Encoder phase A uses lower byte, phase B upper byte.
// - Encoder home uses upper byte, index lower byte.
// - Bits without a select field, other than the lock bit, ignore writes and read zero.
// - All select fields are read/write and reset to zero.
// - While lock bit is set, writes to select registers are ignored, with no error response.
`timescale 1ns/1ps
`default_nettype none
`include "rmis_defines.vh"

module rmis_top #(
    parameter NPINS = 256
) (
    // Clock and reset
    input wire SYS_CLK_I,
    input wire RST_B_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [3:0] PSTRB_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // Remappable pins, levels already synchronous
    input wire [NPINS-1:0] REMAPPABLE_PIN_N_I,
    // Routed peripheral inputs
    output wire TIMER_EXT_CLOCK_O,
    output wire [3:0] CAPTURE_O,
    output wire [3:0] CC_TIMER_CLOCK_O,
    output wire COMPARE_FAULT_A_O,
    output wire COMPARE_FAULT_B_O,
    output wire [3:0] PWM_INPUT_8_11_O,
    output wire ENCODER_PHASE_A_O,
    output wire ENCODER_PHASE_B_O,
    output wire ENCODER_HOME_O,
    output wire ENCODER_INDEX_O
);

    localparam NSEL = 19;

    ////////////////////////////////////////////////////////////////////////////
    // Select field storage, index order fixed below
    // 0 tmr, 1-4 capture, 5-8 cc clock, 9 fault A, 10 fault B,
    // 11-14 pwm 8..11, 15 phase A, 16 phase B, 17 home, 18 index
    reg [7:0] sel_r [0:NSEL-1];
    reg remap_write_lock_r;

    // Field index for a byte lane of a register, NSEL if unimplemented
    function [4:0] field_of;
        input [11:0] a;
        input hi;
        begin
            field_of = NSEL;
            if (a == `RMIS_OFF_TMRCLK) begin
                field_of = hi ? 5'd0 : NSEL;
            end else if (a == `RMIS_OFF_CAP1) begin
                field_of = hi ? 5'd1 : 5'd5;
            end else if (a == `RMIS_OFF_CAP2) begin
                field_of = hi ? 5'd2 : 5'd6;
            end else if (a == `RMIS_OFF_CAP3) begin
                field_of = hi ? 5'd3 : 5'd7;
            end else if (a == `RMIS_OFF_CAP4) begin
                field_of = hi ? 5'd4 : 5'd8;
            end else if (a == `RMIS_OFF_FAULT) begin
                field_of = hi ? 5'd10 : 5'd9;
            end else if (a == `RMIS_OFF_PWM89) begin
                field_of = hi ? 5'd12 : 5'd11;
            end else if (a == `RMIS_OFF_PWM1011) begin
                field_of = hi ? 5'd14 : 5'd13;
            end else if (a == `RMIS_OFF_ENCAB) begin
                field_of = hi ? 5'd16 : 5'd15;
            end else if (a == `RMIS_OFF_ENCHI) begin
                field_of = hi ? 5'd17 : 5'd18;
            end
        end
    endfunction

    wire [4:0] fld_hi = field_of(PADDR_I, 1'b1);
    wire [4:0] fld_lo = field_of(PADDR_I, 1'b0);
    wire is_lock = (PADDR_I == `RMIS_OFF_LOCK);
    wire is_sel = (PADDR_I == `RMIS_OFF_TMRCLK) || (fld_lo != NSEL);
    wire mapped = is_lock || is_sel;
    wire access = PSEL_I && PENABLE_I;
    wire wr = access && PWRITE_I;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; zero-wait-state slave
    genvar g;
    generate
        for (g = 0; g < NSEL; g = g + 1) begin : g_sel
            always @(posedge SYS_CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    sel_r[g] <= `RMIS_SEL_RST;
                end else if (wr && !remap_write_lock_r) begin
                    if (fld_hi == g && PSTRB_I[1]) begin
                        sel_r[g] <= PWDATA_I[`RMIS_HI_MSB:`RMIS_HI_LSB];
                    end else if (fld_lo == g && PSTRB_I[0]) begin
                        sel_r[g] <= PWDATA_I[`RMIS_LO_MSB:`RMIS_LO_LSB];
                    end
                end
            end
        end
    endgenerate

    // Lock itself stays writable, otherwise it could never be released
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            remap_write_lock_r <= `RMIS_LOCK_RST;
        end else if (wr && is_lock && PSTRB_I[1]) begin
            remap_write_lock_r <= PWDATA_I[`RMIS_LOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; answer registered in the setup cycle, ready in access
    reg [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h00000000;
        if (is_lock) begin
            rdata_nxt[`RMIS_LOCK_BIT] = remap_write_lock_r;
        end else begin
            if (fld_hi != NSEL) begin
                rdata_nxt[`RMIS_HI_MSB:`RMIS_HI_LSB] = sel_r[fld_hi];
            end
            if (fld_lo != NSEL) begin
                rdata_nxt[`RMIS_LO_MSB:`RMIS_LO_LSB] = sel_r[fld_lo];
            end
        end
    end

    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PRDATA_O <= 32'h00000000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
            PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? rdata_nxt : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing; pin direction is left to software
    wire [NSEL-1:0] routed;
    generate
        for (g = 0; g < NSEL; g = g + 1) begin : g_pick
            rmis_pin_pick #(.NPINS(NPINS)) u_pick (
                .clk_i(SYS_CLK_I),
                .rst_b_i(RST_B_I),
                .sel_i(sel_r[g]),
                .pins_i(REMAPPABLE_PIN_N_I),
                .out_o(routed[g])
            );
        end
    endgenerate

    assign TIMER_EXT_CLOCK_O = routed[0];
    assign CAPTURE_O = routed[4:1];
    assign CC_TIMER_CLOCK_O = routed[8:5];
    assign COMPARE_FAULT_A_O = routed[9];
    assign COMPARE_FAULT_B_O = routed[10];
    assign PWM_INPUT_8_11_O = routed[14:11];
    assign ENCODER_PHASE_A_O = routed[15];
    assign ENCODER_PHASE_B_O = routed[16];
    assign ENCODER_HOME_O = routed[17];
    assign ENCODER_INDEX_O = routed[18];

endmodule // rmis_top

`default_nettype wire

/* verif/rmis_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side pins; a shift chain makes every pin differ from its neighbours over time
module rmis_pin_model #(parameter NPINS = 256) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bit 2 floods all pins with bit 1, else bit 0 enters the chain
    input wire logic [2:0] ctl_i,
    // Pin levels
    output logic [NPINS-1:0] pins_o
);
    // Pins carry inputs only and are never driven back
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_o <= {NPINS{1'b0}};
        end else begin
            pins_o <= ctl_i[2] ? {NPINS{ctl_i[1]}} : {pins_o[NPINS-2:0], ctl_i[0]};
        end
    end
endmodule // rmis_pin_model
`default_nettype wire

/* verif/rmis_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rmis_top_monitor #(parameter NPINS = 256) (
    // Bus
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // Pins and routed inputs
    input wire logic [NPINS-1:0] REMAPPABLE_PIN_N_I,
    input wire logic TIMER_EXT_CLOCK_O,
    input wire logic [3:0] CAPTURE_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_acc; PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I; endsequence
    property p_rdy; s_acc |-> PREADY_O; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access");
    property p_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_idle; !PREADY_O |-> PRDATA_O == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data outside access");
    property p_unmap; PREADY_O && PADDR_I == 12'h004 |-> PSLVERR_O && PRDATA_O == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_map; PREADY_O && PADDR_I == 12'h00c |-> !PSLVERR_O; endproperty
    a_map: assert property (p_map) else $error("mapped refused");
    property p_tlo; PREADY_O && PADDR_I == 12'h008 |-> PRDATA_O[7:0] == 8'h00; endproperty
    a_tlo: assert property (p_tlo) else $error("empty byte not zero");
    property p_up; PREADY_O |-> PRDATA_O[31:16] == 16'h0; endproperty
    a_up: assert property (p_up) else $error("upper half not zero");
    // Routing checked only when every pin agrees, so no select shadow is needed
    property p_hi; $past(RST_B_I) && $past(&REMAPPABLE_PIN_N_I) |-> TIMER_EXT_CLOCK_O && &CAPTURE_O;
    endproperty
    a_hi: assert property (p_hi) else $error("route lost high");
    property p_lo; $past(RST_B_I) && $past(~|REMAPPABLE_PIN_N_I) |-> !TIMER_EXT_CLOCK_O && CAPTURE_O == 4'h0;
    endproperty
    a_lo: assert property (p_lo) else $error("route lost low");
endmodule // rmis_top_monitor
bind rmis_top rmis_top_monitor #(.NPINS(NPINS)) i_mon (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .REMAPPABLE_PIN_N_I(REMAPPABLE_PIN_N_I),
    .TIMER_EXT_CLOCK_O(TIMER_EXT_CLOCK_O), .CAPTURE_O(CAPTURE_O));
`default_nettype wire

/* verif/tb_remappable_input_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_remappable_input_select;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [1:0] mode = 2'h0;
    logic [3:0] pstrb = 4'h0, s;
    logic [11:0] paddr = 12'h000;
    logic [11:0] adr [10] = '{12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h02c, 12'h030,
        12'h034, 12'h038, 12'h03c};
    logic [15:0] sh [10], m;
    logic [31:0] pwdata = 32'h0, seed = 32'h00014aa7, pseed = 32'h00005a5a, rd, d;
    logic [255:0] pins, p;
    wire logic [31:0] prdata;
    wire logic pready, pslverr;
    wire logic [18:0] outs;
    int bad_count = 0, num_checks = 0;
    rmis_pin_model i_pins (.clk_i(clk), .rst_b_i(rst_b), .ctl_i({mode, pseed[0]}), .pins_o(pins));
    rmis_top i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .REMAPPABLE_PIN_N_I(pins),
        .TIMER_EXT_CLOCK_O(outs[18]), .CAPTURE_O(outs[17:14]), .CC_TIMER_CLOCK_O(outs[13:10]),
        .COMPARE_FAULT_B_O(outs[9]), .COMPARE_FAULT_A_O(outs[8]), .PWM_INPUT_8_11_O(outs[7:4]),
        .ENCODER_PHASE_B_O(outs[3]), .ENCODER_PHASE_A_O(outs[2]), .ENCODER_HOME_O(outs[1]),
        .ENCODER_INDEX_O(outs[0]));
    ////////////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] nx(logic [31:0] v); return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic h(int i); return p[sh[i][15:8]]; endfunction
    function logic l(int i); return p[sh[i][7:0]]; endfunction
    initial forever #2 clk = ~clk;
    always @(posedge clk) pseed <= nx(pseed);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Always leaves one idle edge, so back-to-back calls never drive psel twice in a step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dw, input logic [3:0] st);
        int n;
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= dw; pstrb <= st;
        @(posedge clk); pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata; err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task route;
        @(posedge clk); p = pins;
        @(posedge clk); chk(32'(outs), 32'({h(0), h(4), h(3), h(2), h(1), l(4), l(3), l(2), l(1),
            h(5), l(5), h(7), l(7), h(6), l(6), h(8), l(8), h(9), l(9)}));
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin repeat (20000) @(posedge clk); bad_count++; stop_test; end
    initial begin
        for (int i = 0; i < 10; i++) sh[i] = 16'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin apb(0, adr[i], 0, 0); chk(rd, 0); end
        $display("reset values done");
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 10; i++) begin
                seed = nx(seed);
                d = (k == 1) ? 32'hffffffff : seed;
                s = (k < 2) ? 4'hf : seed[27:24];
                apb(1, adr[i], d, s);
                m = {{8{s[1]}}, {8{s[0]}}} & ((i == 0) ? 16'hff00 : 16'hffff);
                sh[i] = (sh[i] & ~m) | (d[15:0] & m);
                apb(0, adr[i], 0, 0); chk(rd, {16'h0, sh[i]});
            end
            route;
        end
        $display("random selects done");
        for (int f = 2; f < 4; f++) begin mode <= f[1:0]; route; route; end
        mode <= 2'h0;
        $display("flooded pins done");
        apb(1, 12'h000, 32'h00000800, 4'hf);
        apb(0, 12'h000, 0, 0); chk(rd, 32'h00000800);
        apb(1, adr[3], ~{16'h0, sh[3]}, 4'hf);
        apb(0, adr[3], 0, 0); chk(rd, {16'h0, sh[3]});
        apb(1, 12'h000, 32'h0, 4'hf);
        apb(1, adr[3], 32'h0000a55a, 4'hf);
        apb(0, adr[3], 0, 0); chk(rd, 32'h0000a55a);
        $display("lock done");
        apb(0, 12'h004, 0, 0); chk({31'h0, err}, 1);
        chk(rd, 0);
        $display("unmapped done");
        stop_test;
    end
endmodule // tb_remappable_input_select
`default_nettype wire
